// ==== pkg/incx_pkg.sv ====
// constants and types shared by the increment execution block
package incx_pkg;

  localparam int unsigned INCX_DATA_W = 8;
  localparam int unsigned INCX_FADDR_W = 5;
  localparam int unsigned INCX_FILE_DEPTH = 32;
  localparam int unsigned INCX_INSTR_W = 12;

  // instruction word fields
  localparam int unsigned INCX_FADDR_LSB = 0;
  localparam int unsigned INCX_DEST_BIT = 5;
  localparam int unsigned INCX_OPC_LSB = 6;
  localparam int unsigned INCX_OPC_W = 6;

  // opcode field values, bits 11:6 of the instruction word
  localparam logic [5:0] INCX_OPC_INC = 6'h0a;
  localparam logic [5:0] INCX_OPC_INC_SKIP = 6'h0f;

  // destination select values
  localparam logic INCX_DEST_ACC = 1'b0;
  localparam logic INCX_DEST_FILE = 1'b1;

  // reset values
  localparam logic [7:0] INCX_ACC_RST = 8'h00;
  localparam logic [7:0] INCX_FILE_RST = 8'h00;
  localparam logic INCX_ZERO_RST = 1'b0;

  // increment step and the value that wraps to zero
  localparam logic [7:0] INCX_STEP = 8'h01;
  localparam logic [7:0] INCX_ALL_ONES = 8'hff;

  typedef enum logic [1:0] {
    INCX_OP_NONE,
    increment_file_reg,
    increment_then_skip_on_null
  } incx_op_e;

  typedef enum logic {
    INCX_ST_RUN,
    INCX_ST_DISCARD
  } incx_state_e;

endpackage

// ==== rtl/incx_alu.sv ====
// modulo-256 incrementer with zero detect
`timescale 1ns/1ps
`default_nettype none

module incx_alu
  import incx_pkg::*;
(
  input wire logic [7:0] operand,
  output logic [7:0] sum,
  output logic is_zero
);

  // (RL8) wrap modulo 256
  // the carry out is dropped on purpose: no carry flag is touched
  assign sum = 8'(operand + INCX_STEP);

  assign is_zero = (sum == 8'h00);

endmodule

`default_nettype wire

// ==== rtl/incx_exec.sv ====
// execution of the plain increment and the increment-and-skip instructions
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// (RL1) increment register, zero flag follows result
// (RL2) destination bit 0 writes accumulator only
// (RL3) destination bit 1 writes register back
// (RL4) increment-and-skip leaves status flags unchanged
// (RL5) skip only when result is zero
// (RL6) skip discards fetched instruction as idle
// (RL7) one word; one cycle, two if skipping
// (RL8) increment wraps modulo 256, no carry
module incx_exec
  import incx_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [11:0] instr_word,
  input wire logic pre_wr_en,
  input wire logic [4:0] pre_wr_addr,
  input wire logic [7:0] pre_wr_data,
  input wire logic [4:0] peek_addr,
  output logic [7:0] peek_data,
  output logic [7:0] acc,
  output logic zero_flag,
  output logic exec_done,
  output logic skip_taken,
  output logic idle_slot,
  output logic unhandled
);

  logic [7:0] file_q [INCX_FILE_DEPTH];
  incx_state_e state;
  incx_op_e op;
  logic [5:0] opc;
  logic dest;
  logic [4:0] faddr;
  logic [7:0] operand;
  logic [7:0] sum;
  logic is_zero;
  logic accept;
  logic discard;

  assign opc = instr_word[INCX_OPC_LSB +: INCX_OPC_W];
  assign dest = instr_word[INCX_DEST_BIT];
  assign faddr = instr_word[INCX_FADDR_LSB +: INCX_FADDR_W];

  // (RL1) decode the two opcodes
  always_comb
  begin
    case (opc)
      INCX_OPC_INC: op = increment_file_reg;
      INCX_OPC_INC_SKIP: op = increment_then_skip_on_null;
      default: op = INCX_OP_NONE;
    endcase
  end

  // (RL6) slot after a skip is swallowed
  assign discard = instr_valid && (state == INCX_ST_DISCARD);
  assign accept = instr_valid && (state == INCX_ST_RUN) && (op != INCX_OP_NONE);

  assign operand = file_q[faddr];

  incx_alu u_alu (
    .operand(operand),
    .sum(sum),
    .is_zero(is_zero)
  );

  // (RL3) write back into the file register
  // an execution write-back drops any preload in that cycle, whatever its address
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < INCX_FILE_DEPTH; i++)
      begin
        file_q[i] <= INCX_FILE_RST;
      end
    end
    else if (accept && dest == INCX_DEST_FILE)
    begin
      file_q[faddr] <= sum;
    end
    else if (pre_wr_en)
    begin
      file_q[pre_wr_addr] <= pre_wr_data;
    end
  end

  // (RL2) accumulator destination
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc <= INCX_ACC_RST;
    end
    else if (accept && dest == INCX_DEST_ACC)
    begin
      acc <= sum;
    end
  end

  // (RL4) only the plain increment touches zero
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      zero_flag <= INCX_ZERO_RST;
    end
    else if (accept && op == increment_file_reg)
    begin
      zero_flag <= is_zero;
    end
  end

  // (RL5) arm the discard on a zero result
  // the next offered word is the prefetched one, however late it comes
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= INCX_ST_RUN;
    end
    else
    begin
      case (state)
        INCX_ST_RUN:
        begin
          if (accept && op == increment_then_skip_on_null && is_zero)
          begin
            state <= INCX_ST_DISCARD;
          end
        end
        INCX_ST_DISCARD:
        begin
          if (instr_valid)
          begin
            state <= INCX_ST_RUN;
          end
        end
        default: state <= INCX_ST_RUN;
      endcase
    end
  end

  // (RL7) retire pulses, second cycle is the idle slot
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      exec_done <= 1'b0;
      skip_taken <= 1'b0;
      idle_slot <= 1'b0;
      unhandled <= 1'b0;
    end
    else
    begin
      exec_done <= accept;
      skip_taken <= accept && (op == increment_then_skip_on_null) && is_zero;
      idle_slot <= discard;
      unhandled <= instr_valid && (state == INCX_ST_RUN) && (op == INCX_OP_NONE);
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      peek_data <= INCX_FILE_RST;
    end
    else
    begin
      peek_data <= file_q[peek_addr];
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  zero_from_result_a: assert property ( // (RL1)
    accept && op == increment_file_reg |=> zero_flag == ($past(sum) == 8'h00))
  else $error("zero flag does not follow increment result");

  acc_dest_a: assert property ( // (RL2)
    accept && dest == INCX_DEST_ACC && !(pre_wr_en && pre_wr_addr == faddr)
    |=> acc == $past(sum) && file_q[$past(faddr)] == $past(operand))
  else $error("accumulator destination wrong or source changed");

  file_dest_a: assert property ( // (RL3)
    accept && dest == INCX_DEST_FILE |=> file_q[$past(faddr)] == $past(sum) && $stable(acc))
  else $error("file destination not written back");

  skip_keeps_status_a: assert property ( // (RL4)
    accept && op == increment_then_skip_on_null |=> $stable(zero_flag))
  else $error("skip form changed zero flag");

  skip_on_zero_a: assert property ( // (RL5)
    accept && op == increment_then_skip_on_null
    |=> (state == INCX_ST_DISCARD) == $past(is_zero) && skip_taken == $past(is_zero))
  else $error("skip decision does not match result");

  discard_idle_a: assert property ( // (RL6)
    discard |=> idle_slot && !exec_done && $stable(acc) && $stable(zero_flag)
    && state == INCX_ST_RUN)
  else $error("discarded instruction was executed");

  plain_one_cycle_a: assert property ( // (RL7)
    accept && op == increment_file_reg |=> exec_done && state == INCX_ST_RUN)
  else $error("plain increment took more than one cycle");

  skip_two_cycle_a: assert property ( // (RL7)
    accept && op == increment_then_skip_on_null && is_zero ##1 instr_valid
    |=> idle_slot ##1 !idle_slot)
  else $error("skip slot not exactly one cycle");

  wrap_zero_a: assert property ( // (RL8)
    accept && dest == INCX_DEST_ACC && operand == INCX_ALL_ONES |=> acc == 8'h00)
  else $error("all ones did not wrap to zero");

  inc_cover_c: cover property (accept && op == increment_file_reg && is_zero);
  skip_cover_c: cover property (accept && op == increment_then_skip_on_null ##1 discard);
  noskip_cover_c: cover property (accept && op == increment_then_skip_on_null && !is_zero);

endmodule

`default_nettype wire

// ==== dv/incx_exec_tb.sv ====
// self-checking bench for the increment execution block
`timescale 1ns/1ps
`default_nettype none
module incx_exec_tb
  import incx_pkg::*;
;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic instr_valid = 1'b0;
  logic [11:0] instr_word = 12'h000;
  logic pre_wr_en = 1'b0;
  logic [4:0] pre_wr_addr = 5'h00;
  logic [7:0] pre_wr_data = 8'h00;
  logic [4:0] peek_addr = 5'h00;
  logic [7:0] peek_data, acc, acc_m, peek_m;
  logic zero_flag, exec_done, skip_taken, idle_slot, unhandled, z_m, disc_m;
  logic [7:0] file_m [32];
  logic [31:0] sel;
  logic [11:0] rw;
  int miscompares = 0;
  int n_tests = 0;
  int seed = 86880;
  always #2.5 core_clk = ~core_clk;
  incx_exec dut_u (.core_clk, .resetn, .instr_valid, .instr_word, .pre_wr_en,
    .pre_wr_addr, .pre_wr_data, .peek_addr, .peek_data, .acc, .zero_flag,
    .exec_done, .skip_taken, .idle_slot, .unhandled);
  function automatic logic [11:0] wd(logic [5:0] opc, logic d, logic [4:0] a);
    return {opc, d, a};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    chk({7'h00, got}, {7'h00, exp}, what);
  endtask
  task automatic summarize();
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one instruction slot: drive at the falling edge, check after the next rising edge
  task automatic op(input logic v, input logic [11:0] w, input logic pe,
    input logic [4:0] pa, input logic [7:0] pd, input logic [4:0] pk);
    logic [7:0] r;
    logic take, d, skip_m, idle_m, unh_m, inc;
    r = 8'(file_m[w[4:0]] + 8'h01);
    d = w[5];
    inc = (w[11:6] === INCX_OPC_INC);
    take = v && !disc_m && (inc || w[11:6] === INCX_OPC_INC_SKIP);
    idle_m = v && disc_m;
    unh_m = v && !disc_m && !take;
    skip_m = take && !inc && r == 8'h00;
    instr_valid = v;
    instr_word = w;
    pre_wr_en = pe;
    pre_wr_addr = pa;
    pre_wr_data = pd;
    peek_addr = pk;
    peek_m = file_m[pk];
    @(negedge core_clk);
    // execution write-back wins over a preload in the same slot
    if (pe && !(take && d))
      file_m[pa] = pd;
    if (take && d)
      file_m[w[4:0]] = r;
    if (take && !d)
      acc_m = r;
    if (take && inc)
      z_m = (r == 8'h00);
    if (v)
      disc_m = skip_m;
    chk(acc, acc_m, "acc");
    chk(peek_data, peek_m, "file");
    chk1(zero_flag, z_m, "zero");
    chk1(exec_done, take, "done");
    chk1(skip_taken, skip_m, "skip");
    chk1(idle_slot, idle_m, "idle");
    chk1(unhandled, unh_m, "other");
  endtask
  task automatic idle(input logic [4:0] pk);
    op(1'b0, 12'h000, 1'b0, 5'h00, 8'h00, pk);
  endtask
  initial
  begin
    #50000;
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    summarize();
  end
  initial
  begin
    foreach (file_m[i])
      file_m[i] = 8'h00;
    acc_m = 8'h00;
    z_m = 1'b0;
    disc_m = 1'b0;
    repeat (8) @(negedge core_clk);
    resetn = 1'b1;
    idle(5'h03);
    $display("test reset done");
    op(1'b0, 12'h000, 1'b1, 5'h03, 8'hff, 5'h03);
    op(1'b1, wd(INCX_OPC_INC, 1'b0, 5'h03), 1'b0, 5'h00, 8'h00, 5'h03);
    op(1'b1, wd(INCX_OPC_INC, 1'b1, 5'h03), 1'b0, 5'h00, 8'h00, 5'h03);
    op(1'b1, wd(INCX_OPC_INC, 1'b1, 5'h03), 1'b0, 5'h00, 8'h00, 5'h03);
    idle(5'h03);
    $display("test wrap done");
    // skip with the next word back to back, then one after a gap
    op(1'b0, 12'h000, 1'b1, 5'h02, 8'hff, 5'h02);
    op(1'b1, wd(INCX_OPC_INC_SKIP, 1'b1, 5'h02), 1'b1, 5'h04, 8'hff, 5'h02);
    // preload beside the skip write-back is dropped, the one in the discarded slot lands
    op(1'b1, wd(INCX_OPC_INC, 1'b0, 5'h07), 1'b1, 5'h04, 8'hff, 5'h02);
    op(1'b1, wd(INCX_OPC_INC_SKIP, 1'b0, 5'h09), 1'b0, 5'h00, 8'h00, 5'h09);
    op(1'b1, wd(INCX_OPC_INC_SKIP, 1'b0, 5'h04), 1'b0, 5'h00, 8'h00, 5'h04);
    idle(5'h04);
    idle(5'h04);
    op(1'b1, wd(INCX_OPC_INC, 1'b1, 5'h04), 1'b0, 5'h00, 8'h00, 5'h04);
    idle(5'h04);
    $display("test skip done");
    op(1'b1, wd(INCX_OPC_INC, 1'b1, 5'h01), 1'b1, 5'h06, 8'h55, 5'h06);
    op(1'b1, wd(INCX_OPC_INC, 1'b0, 5'h06), 1'b1, 5'h06, 8'h77, 5'h06);
    op(1'b1, 12'hfff, 1'b0, 5'h00, 8'h00, 5'h06);
    $display("test collide done");
    // reset in mid-run must clear accumulator and file registers again
    resetn = 1'b0;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    foreach (file_m[i])
      file_m[i] = 8'h00;
    acc_m = 8'h00;
    z_m = 1'b0;
    disc_m = 1'b0;
    idle(5'h06);
    $display("test midreset done");
    repeat (3000)
    begin
      sel = $random(seed);
      rw = 12'($random(seed));
      if (sel[1:0] == 2'h0)
        rw[11:6] = INCX_OPC_INC;
      else if (sel[1:0] != 2'h3)
        rw[11:6] = INCX_OPC_INC_SKIP;
      op(sel[2] | sel[3], rw, sel[4] & sel[5], sel[20:16],
        sel[6] ? 8'hff : sel[15:8], sel[25:21]);
    end
    $display("test random done");
    summarize();
  end
endmodule
`default_nettype wire
